// ---- lce_pkg.sv ----
// Constants, encodings and register map of the logic equation and comparator engine.
// Assumes a 50 MHz clock and a classic Wishbone slave with 32-bit data.
package lce_pkg;
	localparam int unsigned CLK_HZ           = 50_000_000;
	localparam int unsigned PASS_PERIOD_US   = 1000;
	localparam int unsigned PASS_CYCLES_DFLT = CLK_HZ / 1_000_000 * PASS_PERIOD_US;
	localparam int unsigned PASSES_PER_SEC   = 1_000_000 / PASS_PERIOD_US;
	localparam int unsigned STORE_DEPTH      = 512;
	localparam int unsigned NUM_TIMERS       = 32;
	localparam int unsigned NUM_CMP          = 8;
	localparam int unsigned NUM_AIN          = 8;
	localparam int unsigned NUM_LATCH        = 16;
	localparam int unsigned NUM_VOUT         = 64;
	localparam int unsigned STACK_DEPTH      = 16;

	// Register byte addresses
	localparam logic [11:0] ADR_CTRL     = 12'h000;
	localparam logic [11:0] ADR_STATUS   = 12'h004;
	localparam logic [11:0] ADR_ELEM_EN  = 12'h008;
	localparam logic [11:0] ADR_VIN      = 12'h00c;
	localparam logic [11:0] ADR_VOUT_LO  = 12'h010;
	localparam logic [11:0] ADR_VOUT_HI  = 12'h014;
	localparam logic [11:0] ADR_TMR_UNIT = 12'h018;
	localparam logic [11:0] ADR_LATCH    = 12'h01c;
	localparam logic [3:0]  PAGE_TMR     = 4'h1;
	localparam logic [3:0]  PAGE_CMP     = 4'h2;
	localparam logic [2:0]  CMP_W_STAT   = 3'h6;

	// Comparator setting word layout
	localparam int CF_EN = 0, CF_POS = 1, CF_NEG = 5, CF_ABS = 9, CF_DELTA = 10;
	localparam int CF_UNDER = 11, CF_BLK_EN = 12, CF_BLK_IDX = 13;
	localparam logic signed [33:0] THR_MAX = 34'sd90000;
	localparam logic [9:0]  HYS_MIN  = 10'd1;
	localparam logic [9:0]  HYS_MAX  = 10'd500;
	localparam logic [47:0] HYS_DIV  = 48'd1000;
	localparam logic [16:0] RATE_MIN = 17'd20;
	localparam logic [16:0] RATE_MAX = 17'd86400;
	localparam logic [15:0] MS_PER_MS  = 16'd1;
	localparam logic [15:0] MS_PER_S   = 16'd1000;
	localparam logic [15:0] MS_PER_MIN = 16'd60000;

	typedef enum logic [3:0] {
		OP_END, OP_ON, OP_OFF, OP_VOUT, OP_VIN, OP_CONTACT, OP_ELEM, OP_CMP_PKP,
		OP_CMP_OP, OP_NOT, OP_OR, OP_AND, OP_XOR, OP_LATCH, OP_TIMER, OP_ASSIGN
	} lce_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_CMP} lce_state_t;
endpackage

// ---- lce_engine.sv ----
// Logic equation evaluator with timers and analog comparators, Wishbone slave.
// Assumes synchronous inputs and a classic single-cycle Wishbone master.
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lce_engine import lce_pkg::*; #(
	parameter int unsigned PASS_CYCLES = PASS_CYCLES_DFLT
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [11:0]            wb_adr_i,
	input  wire logic [31:0]            wb_dat_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            contact_input,
	input  wire logic [31:0]            digital_element,
	input  wire logic [NUM_AIN*32-1:0]  ain_value,
	input  wire logic [NUM_AIN*4-1:0]   ain_type,
	output logic                        wb_ack_o,
	output logic [31:0]                 wb_dat_o,
	output logic [NUM_VOUT-1:0]         virtual_output,
	output logic [NUM_CMP-1:0]          cmp_pickup,
	output logic [NUM_CMP-1:0]          cmp_operate
);

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
	                                       input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Returns {output, count}; count steps once per update
	function automatic logic [16:0] dly_step(input logic din, input logic dout,
	                                         input logic [15:0] cnt, input logic [15:0] pu,
	                                         input logic [15:0] dr);
		logic [15:0] lim;
		lim = din ? pu : dr;
		if (din == dout) begin
			return {dout, 16'h0};
		end
		if (cnt >= lim) begin
			return {din, 16'h0};
		end
		return {dout, cnt + 16'h1};
	endfunction

	function automatic logic [15:0] stk_reduce(input logic [15:0] s, input lce_op_t op,
	                                           input logic [7:0] n);
		logic        r;
		logic [4:0]  k;
		logic [15:0] sh;
		r = (op == OP_AND);
		k = (n > 8'd16) ? 5'd16 : ((n == 8'h0) ? 5'd1 : n[4:0]);
		for (int i = 0; i < STACK_DEPTH; i++) begin
			if (i < k) begin
				unique case (op)
					OP_AND:  r = r & s[i];
					OP_OR:   r = r | s[i];
					default: r = r ^ s[i];
				endcase
			end
		end
		sh = s >> k;
		return {sh[14:0], r};
	endfunction

	// Settings and bus
	logic [15:0] store [0:STORE_DEPTH-1];
	logic [31:0] tmr_dly [0:NUM_TIMERS-1];
	logic [31:0] cmp_cfg [0:NUM_CMP*8-1];
	logic [STORE_DEPTH-1:0] written_reg, written_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] elem_en_reg, elem_en_next;
	logic [31:0] vin_reg, vin_next;
	logic [31:0] tunit_reg, tunit_next;
	logic        wr_en, setting_wr;
	logic [15:0] status_reg, status_next;
	logic [15:0] store_rd;
	logic [31:0] store_wd;

	// Evaluator
	lce_state_t  state_reg, state_next;
	logic [8:0]  pc_reg, pc_next;
	logic [15:0] stk_reg, stk_next;
	logic [NUM_VOUT-1:0] vo_reg, vo_next;
	logic [NUM_LATCH-1:0] latch_reg, latch_next;
	logic [31:0] tin_reg, tin_next;
	logic [31:0] tick_reg, tick_next;
	logic [15:0] passes_reg, passes_next;
	logic [9:0]  sec_reg, sec_next;
	logic        sec_tick_reg, sec_tick_next;
	logic [2:0]  cidx_reg, cidx_next;
	logic        ended_reg, ended_next;
	logic        pass_done;
	logic [15:0] entry;
	lce_op_t     op;
	logic [7:0]  arg;

	// Timers
	logic [31:0] tout_reg, tout_next;
	logic [15:0] tcnt [0:NUM_TIMERS-1];
	logic [15:0] tcnt_next [0:NUM_TIMERS-1];

	// Comparators
	logic [NUM_CMP-1:0] pkp_reg, op_reg;
	logic [15:0]        ccnt [0:NUM_CMP-1];
	logic signed [33:0] snap [0:NUM_CMP-1];
	logic signed [33:0] dval [0:NUM_CMP-1];
	logic [32:0]        wcnt [0:NUM_CMP-1];
	logic               c_pkp, c_op;
	logic [15:0]        c_cnt;
	logic signed [33:0] c_snap, c_dval;
	logic [32:0]        c_wcnt;

	assign wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	assign setting_wr = wr_en & (wb_adr_i != ADR_VIN);
	assign pass_done  = (state_reg == ST_SCAN) & ((op == OP_END) | (pc_reg == 9'h1ff));
	assign entry      = written_reg[pc_reg] ? store[pc_reg] : 16'h0;
	assign op         = lce_op_t'(entry[11:8]);
	assign arg        = entry[7:0];
	assign store_rd   = written_reg[wb_adr_i[10:2]] ? store[wb_adr_i[10:2]] : 16'h0;
	assign store_wd   = wmerge({16'h0, store_rd}, wb_dat_i, wb_sel_i);

	always_comb begin
		logic [2:0] cw;
		cw = wb_adr_i[4:2];
		ack_next     = wb_cyc_i & wb_stb_i & ~ack_reg;
		written_next = written_reg;
		ctrl_next    = ctrl_reg;
		elem_en_next = elem_en_reg;
		vin_next     = vin_reg;
		tunit_next   = tunit_reg;
		rdata_next   = 32'h0;
		if (wr_en && wb_adr_i[11]) begin
			written_next[wb_adr_i[10:2]] = 1'b1;
		end
		if (wr_en) begin
			unique case (wb_adr_i)
				ADR_CTRL:     ctrl_next    = wmerge(ctrl_reg, wb_dat_i, wb_sel_i);
				ADR_ELEM_EN:  elem_en_next = wmerge(elem_en_reg, wb_dat_i, wb_sel_i);
				ADR_VIN:      vin_next     = wmerge(vin_reg, wb_dat_i, wb_sel_i);
				ADR_TMR_UNIT: tunit_next   = wmerge(tunit_reg, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
		if (wb_adr_i[11]) begin
			rdata_next = {16'h0, store_rd};
		end else if (wb_adr_i[11:8] == PAGE_TMR && !wb_adr_i[7]) begin
			rdata_next = tmr_dly[wb_adr_i[6:2]];
		end else if (wb_adr_i[11:8] == PAGE_CMP) begin
			if (cw == CMP_W_STAT) begin
				rdata_next = {30'h0, op_reg[wb_adr_i[7:5]], pkp_reg[wb_adr_i[7:5]]};
			end else if (cw < CMP_W_STAT) begin
				rdata_next = cmp_cfg[{wb_adr_i[7:5], cw}];
			end
		end else begin
			unique case (wb_adr_i)
				ADR_CTRL:     rdata_next = ctrl_reg;
				ADR_STATUS:   rdata_next = {status_reg, 13'h0, ended_reg,
				                            state_reg != ST_IDLE, ctrl_reg[0]};
				ADR_ELEM_EN:  rdata_next = elem_en_reg;
				ADR_VIN:      rdata_next = vin_reg;
				ADR_VOUT_LO:  rdata_next = vo_reg[31:0];
				ADR_VOUT_HI:  rdata_next = vo_reg[63:32];
				ADR_TMR_UNIT: rdata_next = tunit_reg;
				ADR_LATCH:    rdata_next = {16'h0, latch_reg};
				default:      rdata_next = 32'h0;
			endcase
		end
		status_next = passes_reg;
	end

	always_ff @(posedge clk) begin
		if (wr_en && wb_adr_i[11]) begin
			store[wb_adr_i[10:2]] <= store_wd[15:0];
		end
	end

	// Timer and comparator settings start cleared so unused ones stay idle
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int t = 0; t < NUM_TIMERS; t++) begin
				tmr_dly[t] <= 32'h0;
			end
			for (int c = 0; c < NUM_CMP * 8; c++) begin
				cmp_cfg[c] <= 32'h0;
			end
		end else begin
			if (wr_en && wb_adr_i[11:8] == PAGE_TMR && !wb_adr_i[7]) begin
				tmr_dly[wb_adr_i[6:2]] <= wmerge(tmr_dly[wb_adr_i[6:2]], wb_dat_i,
				                                 wb_sel_i);
			end
			if (wr_en && wb_adr_i[11:8] == PAGE_CMP && wb_adr_i[4:2] < CMP_W_STAT) begin
				cmp_cfg[wb_adr_i[7:2]] <= wmerge(cmp_cfg[wb_adr_i[7:2]], wb_dat_i,
				                                 wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_reg     <= 1'b0;
			rdata_reg   <= 32'h0;
			written_reg <= '0;
			ctrl_reg    <= 32'h0;
			elem_en_reg <= 32'h0;
			vin_reg     <= 32'h0;
			tunit_reg   <= 32'h0;
			status_reg  <= 16'h0;
		end else begin
			ack_reg     <= ack_next;
			rdata_reg   <= rdata_next;
			written_reg <= written_next;
			ctrl_reg    <= ctrl_next;
			elem_en_reg <= elem_en_next;
			vin_reg     <= vin_next;
			tunit_reg   <= tunit_next;
			status_reg  <= status_next;
		end
	end

	// Equation scan
	always_comb begin
		logic b;
		state_next    = state_reg;
		pc_next       = pc_reg;
		stk_next      = stk_reg;
		vo_next       = vo_reg;
		latch_next    = latch_reg;
		tin_next      = tin_reg;
		passes_next   = passes_reg;
		sec_next      = sec_reg;
		sec_tick_next = sec_tick_reg;
		cidx_next     = cidx_reg;
		ended_next    = ended_reg;
		tick_next     = (tick_reg == PASS_CYCLES - 1) ? 32'h0 : tick_reg + 32'h1;
		b             = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (tick_reg == PASS_CYCLES - 1 && ctrl_reg[0]) begin
					state_next = ST_SCAN;
					pc_next    = 9'h0;
					stk_next   = 16'h0;
				end
			end
			ST_SCAN: begin
				pc_next = pc_reg + 9'h1;
				unique case (op)
					OP_ON:      b = 1'b1;
					OP_OFF:     b = 1'b0;
					OP_VOUT:    b = vo_reg[arg[5:0]];
					OP_VIN:     b = vin_reg[arg[4:0]];
					OP_CONTACT: b = contact_input[arg[4:0]];
					OP_ELEM:    b = digital_element[arg[4:0]] & elem_en_reg[arg[4:0]];
					OP_CMP_PKP: b = pkp_reg[arg[2:0]];
					OP_CMP_OP:  b = op_reg[arg[2:0]];
					default:    b = 1'b0;
				endcase
				unique case (op)
					OP_END: ;
					OP_ON, OP_OFF, OP_VOUT, OP_VIN, OP_CONTACT, OP_ELEM, OP_CMP_PKP,
					OP_CMP_OP: stk_next = {stk_reg[14:0], b};
					OP_NOT:    stk_next[0] = ~stk_reg[0];
					OP_OR, OP_AND, OP_XOR: stk_next = stk_reduce(stk_reg, op, arg);
					OP_LATCH: begin
						if (stk_reg[0]) begin
							latch_next[arg[3:0]] = 1'b0;
						end else if (stk_reg[1]) begin
							latch_next[arg[3:0]] = 1'b1;
						end
						stk_next = {1'b0, stk_reg[15:2], latch_next[arg[3:0]]};
					end
					OP_TIMER: begin
						tin_next[arg[4:0]] = stk_reg[0];
						stk_next[0]        = tout_reg[arg[4:0]];
					end
					OP_ASSIGN: begin
						vo_next[arg[5:0]] = stk_reg[0];
						stk_next          = stk_reg >> 1;
					end
				endcase
				if (pass_done) begin
					state_next    = ST_CMP;
					cidx_next     = 3'h0;
					ended_next    = (op == OP_END);
					passes_next   = passes_reg + 16'h1;
					sec_tick_next = (sec_reg == 10'(PASSES_PER_SEC - 1));
					sec_next      = sec_tick_next ? 10'h0 : sec_reg + 10'h1;
				end
			end
			ST_CMP: begin
				cidx_next = cidx_reg + 3'h1;
				if (cidx_reg == 3'(NUM_CMP - 1)) begin
					state_next = ST_IDLE;
				end
			end
		endcase
		if (setting_wr) begin
			latch_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg    <= ST_IDLE;
			pc_reg       <= 9'h0;
			stk_reg      <= 16'h0;
			vo_reg       <= '0;
			latch_reg    <= '0;
			tin_reg      <= 32'h0;
			tick_reg     <= 32'h0;
			passes_reg   <= 16'h0;
			sec_reg      <= 10'h0;
			sec_tick_reg <= 1'b0;
			cidx_reg     <= 3'h0;
			ended_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			pc_reg       <= pc_next;
			stk_reg      <= stk_next;
			vo_reg       <= vo_next;
			latch_reg    <= latch_next;
			tin_reg      <= tin_next;
			tick_reg     <= tick_next;
			passes_reg   <= passes_next;
			sec_reg      <= sec_next;
			sec_tick_reg <= sec_tick_next;
			cidx_reg     <= cidx_next;
			ended_reg    <= ended_next;
		end
	end

	// Timers step once per pass; seconds unit steps on every thousandth pass
	always_comb begin
		logic [16:0] r;
		r = 17'h0;
		tout_next = tout_reg;
		for (int t = 0; t < NUM_TIMERS; t++) begin
			tcnt_next[t] = tcnt[t];
			r = dly_step(tin_reg[t], tout_reg[t], tcnt[t], tmr_dly[t][15:0],
			             tmr_dly[t][31:16]);
			if (state_reg == ST_CMP && cidx_reg == 3'h0 &&
			    (!tunit_reg[t] || sec_tick_reg)) begin
				tout_next[t] = r[16];
				tcnt_next[t] = r[15:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tout_reg <= 32'h0;
			for (int t = 0; t < NUM_TIMERS; t++) begin
				tcnt[t] <= 16'h0;
			end
		end else begin
			tout_reg <= tout_next;
			for (int t = 0; t < NUM_TIMERS; t++) begin
				tcnt[t] <= tcnt_next[t];
			end
		end
	end

	// Comparator for index cidx, evaluated once per pass
	always_comb begin
		logic [31:0] cf;
		logic [3:0] ps, ns;
		logic signed [33:0] a, b, lvl, sig, thr, lw;
		logic [9:0] hys;
		logic [16:0] len;
		logic [15:0] scl;
		logic [32:0] wlim;
		logic [47:0] prod;
		logic valid, pick, drop;
		logic [16:0] r;
		r    = 17'h0;
		scl  = MS_PER_MS;
		cf   = cmp_cfg[{cidx_reg, 3'h0}];
		ps   = cf[CF_POS +: 4];
		ns   = cf[CF_NEG +: 4];
		a    = (ps == 4'h0) ? 34'sh0 : 34'(signed'(ain_value[(ps - 4'h1) * 32 +: 32]));
		b    = (ns == 4'h0) ? 34'sh0 : 34'(signed'(ain_value[(ns - 4'h1) * 32 +: 32]));
		lvl  = a - b;
		if (cf[CF_ABS] && lvl < 0) begin
			lvl = -lvl;
		end
		thr  = 34'(signed'(cmp_cfg[{cidx_reg, 3'h1}]));
		thr  = (thr > THR_MAX) ? THR_MAX : ((thr < -THR_MAX) ? -THR_MAX : thr);
		hys  = cmp_cfg[{cidx_reg, 3'h2}][9:0];
		hys  = (hys < HYS_MIN) ? HYS_MIN : ((hys > HYS_MAX) ? HYS_MAX : hys);
		prod = 48'(thr < 0 ? -thr : thr) * 48'(hys) / HYS_DIV;
		lw   = 34'(prod);
		len  = cmp_cfg[{cidx_reg, 3'h3}][16:0];
		len  = (len < RATE_MIN) ? RATE_MIN : ((len > RATE_MAX) ? RATE_MAX : len);
		unique case (cmp_cfg[{cidx_reg, 3'h3}][18:17])
			2'h1:    scl = MS_PER_S;
			2'h2:    scl = MS_PER_MIN;
			default: scl = MS_PER_MS;
		endcase
		wlim   = 33'(len) * 33'(scl);
		c_wcnt = wcnt[cidx_reg] + 33'h1;
		c_snap = snap[cidx_reg];
		c_dval = dval[cidx_reg];
		if (c_wcnt >= wlim) begin
			c_dval = lvl - snap[cidx_reg];
			c_snap = lvl;
			c_wcnt = 33'h0;
		end
		sig   = cf[CF_DELTA] ? c_dval : lvl;
		valid = cf[CF_EN]
		        & ((ps != 4'h0) | (ns != 4'h0))
		        & ~((ps != 4'h0) & (ns != 4'h0) &
		            (ain_type[(ps - 4'h1) * 4 +: 4] != ain_type[(ns - 4'h1) * 4 +: 4]))
		        & ~(cf[CF_BLK_EN] & vo_reg[cf[CF_BLK_IDX +: 6]]);
		pick  = cf[CF_UNDER] ? (sig < thr) : (sig > thr);
		drop  = cf[CF_UNDER] ? (sig > thr + lw) : (sig < thr - lw);
		c_pkp = valid & (pkp_reg[cidx_reg] ? ~drop : pick);
		r     = dly_step(c_pkp, op_reg[cidx_reg], ccnt[cidx_reg],
		                 cmp_cfg[{cidx_reg, 3'h4}][15:0],
		                 cmp_cfg[{cidx_reg, 3'h5}][15:0]);
		c_op  = valid & r[16];
		c_cnt = valid ? r[15:0] : 16'h0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pkp_reg <= '0;
			op_reg  <= '0;
			for (int c = 0; c < NUM_CMP; c++) begin
				ccnt[c] <= 16'h0;
				snap[c] <= 34'sh0;
				dval[c] <= 34'sh0;
				wcnt[c] <= 33'h0;
			end
		end else if (state_reg == ST_CMP) begin
			pkp_reg[cidx_reg] <= c_pkp;
			op_reg[cidx_reg]  <= c_op;
			ccnt[cidx_reg]    <= c_cnt;
			snap[cidx_reg]    <= c_snap;
			dval[cidx_reg]    <= c_dval;
			wcnt[cidx_reg]    <= c_wcnt;
		end
	end

	assign wb_ack_o       = ack_reg;
	assign wb_dat_o       = rdata_reg;
	assign virtual_output = vo_reg;
	assign cmp_pickup     = pkp_reg;
	assign cmp_operate    = op_reg;

endmodule // lce_engine
`default_nettype wire

// ---- lce_engine_monitor.sv ----
// Checker for lce_engine: bus handshake, reset state, unmapped reads, update cadence.
// Bound to lce_engine; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lce_engine_monitor import lce_pkg::*; #(
	parameter int unsigned PASS_CYCLES = PASS_CYCLES_DFLT
) (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [11:0]         wb_adr_i,
	input wire logic                wb_ack_o,
	input wire logic [31:0]         wb_dat_o,
	input wire logic [NUM_VOUT-1:0] virtual_output,
	input wire logic [NUM_CMP-1:0]  cmp_pickup,
	input wire logic [NUM_CMP-1:0]  cmp_operate
);
	logic [15:0]         pkp_age_reg, pkp_age_next, vout_age_reg, vout_age_next;
	logic [NUM_CMP-1:0]  pkp_old_reg;
	logic [NUM_VOUT-1:0] vout_old_reg;

	// Cycles since cmp_pickup and virtual_output each last changed, saturating
	always_comb begin
		pkp_age_next = pkp_age_reg + 16'(pkp_age_reg != 16'hffff);
		vout_age_next = vout_age_reg + 16'(vout_age_reg != 16'hffff);
		if (cmp_pickup != pkp_old_reg)
			pkp_age_next = 16'h0;
		if (virtual_output != vout_old_reg)
			vout_age_next = 16'h0;
		if (rst) begin
			pkp_age_next = 16'hffff;
			vout_age_next = 16'hffff;
		end
	end
	always_ff @(posedge clk) begin
		pkp_age_reg <= pkp_age_next;
		vout_age_reg <= vout_age_next;
		pkp_old_reg <= cmp_pickup;
		vout_old_reg <= virtual_output;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack_answer;
		s_req |=> s_ans;
	endproperty
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	property p_ack_drop;
		$rose(wb_ack_o) |=> $fell(wb_ack_o);
	endproperty
	property p_unmapped_rd;
		wb_ack_o && !wb_we_i && wb_adr_i inside {[12'h300:12'h7fc]} |-> wb_dat_o == 32'h0;
	endproperty
	property p_reset_clear;
		$fell(rst) |-> virtual_output == '0 && cmp_pickup == '0 && cmp_operate == '0;
	endproperty
	property p_operate_rise;
		(cmp_operate & ~$past(cmp_operate) & ~cmp_pickup) == '0;
	endproperty
	property p_pkp_cadence;
		cmp_pickup != pkp_old_reg |-> pkp_age_reg < 16'h8 || pkp_age_reg >= 16'(PASS_CYCLES - 16);
	endproperty
	property p_vout_cadence;
		virtual_output != vout_old_reg |->
			vout_age_reg < 16'h208 || vout_age_reg >= 16'(PASS_CYCLES - 520);
	endproperty

	a_ack_answer: assert property (p_ack_answer) else $error("ack late or too long");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_ack_drop: assert property (p_ack_drop) else $error("ack held over one cycle");
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
	a_reset_clear: assert property (p_reset_clear) else $error("outputs set after reset");
	a_operate_rise: assert property (p_operate_rise) else $error("operate without pickup");
	a_pkp_cadence: assert property (p_pkp_cadence) else $error("pickup off pass cadence");
	a_vout_cadence: assert property (p_vout_cadence) else $error("vout off scan window");
endmodule // lce_engine_monitor

bind lce_engine lce_engine_monitor #(.PASS_CYCLES(PASS_CYCLES)) u_lce_engine_monitor (
	.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.virtual_output(virtual_output), .cmp_pickup(cmp_pickup), .cmp_operate(cmp_operate));
`default_nettype wire

// ---- test_lce_engine.sv ----
// Self-checking bench for lce_engine: bus, equations, latches, timers, comparators.
// Assumes lce_pkg, lce_engine and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_lce_engine import lce_pkg::*; ();
	localparam int unsigned PC = 600;
	logic                  clk, rst, cyc, stb, we, ack;
	logic [3:0]            sel;
	logic [11:0]           adr;
	logic [31:0]           wdat, rdat, rd, contact, elem;
	logic [NUM_AIN*32-1:0] ain;
	logic [NUM_AIN*4-1:0]  atype;
	logic [NUM_VOUT-1:0]   vout;
	logic [NUM_CMP-1:0]    pkp, opr;
	int                    n_errors, n_tests;

	lce_engine #(.PASS_CYCLES(PC)) u_lce_engine (
		.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .contact_input(contact), .digital_element(elem),
		.ain_value(ain), .ain_type(atype), .wb_ack_o(ack), .wb_dat_o(rdat),
		.virtual_output(vout), .cmp_pickup(pkp), .cmp_operate(opr));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic test_done;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic cycle; read data lands in rd
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("wb_lat", 32'h1, 32'(n));
	endtask

	task automatic passes(input int n);
		repeat (n * PC) @(posedge clk);
	endtask

	function automatic logic [31:0] ent(input lce_op_t op, input logic [7:0] arg);
		return {20'h0, op, arg};
	endfunction

	task automatic t_bus;
		wb(1'b0, 12'hffc, 32'h0);
		check("store_dflt", 32'h0, rd);
		wb(1'b1, 12'h400, 32'hffffffff);
		wb(1'b0, 12'h400, 32'h0);
		check("unmapped", 32'h0, rd);
	endtask

	task automatic t_program;
		lce_op_t ops [29] = '{OP_ON, OP_ASSIGN, OP_VOUT, OP_NOT, OP_ASSIGN, OP_OFF, OP_ASSIGN,
			OP_VIN, OP_VIN, OP_LATCH, OP_ASSIGN, OP_VIN, OP_TIMER, OP_ASSIGN, OP_ELEM, OP_ASSIGN,
			OP_VOUT, OP_VIN, OP_OR, OP_ASSIGN, OP_CONTACT, OP_VIN, OP_XOR, OP_ASSIGN,
			OP_CMP_PKP, OP_ASSIGN, OP_END, OP_ON, OP_ASSIGN};
		byte args [29] = '{0, 0, 0, 0, 1, 0, 2, 0, 1, 0, 4, 2, 0, 5, 0, 6, 7, 3, 2, 7,
			0, 4, 2, 8, 0, 9, 0, 0, 10};
		for (int i = 0; i < 29; i++)
			wb(1'b1, 12'h800 + 12'(4 * i), ent(ops[i], 8'(args[i])));
		wb(1'b0, 12'h804, 32'h0);
		check("store_rd", ent(OP_ASSIGN, 8'h0), rd);
		wb(1'b1, ADR_CTRL, 32'h1);
		passes(2);
		check("vout_init", 32'h101, vout[31:0]);
		wb(1'b1, ADR_ELEM_EN, 32'h1);
		passes(2);
		wb(1'b0, ADR_VOUT_LO, 32'h0);
		check("vout_elem", 32'h141, rd);
	endtask

	task automatic t_status;
		logic [15:0] s0;
		wb(1'b0, ADR_STATUS, 32'h0);
		s0 = rd[31:16];
		check("status_end", 32'h5, rd & 32'h5);
		passes(4);
		wb(1'b0, ADR_STATUS, 32'h0);
		check("pass_rate", 32'h1, 32'((rd[31:16] - s0) inside {[3:5]}));
	endtask

	task automatic t_latch;
		logic [4:0] vin [8] = '{5'h1, 5'h0, 5'h2, 5'h8, 5'h0, 5'h10, 5'h1, 5'h0};
		logic [4:0] ev [8] = '{5'h11, 5'h11, 5'h10, 5'h18, 5'h18, 5'h8, 5'h19, 5'h19};
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, ADR_VIN, {27'h0, vin[i]});
			passes(2);
			check("vout_seq", {27'h0, ev[i]}, {27'h0, vout[8:4] & 5'h19});
		end
		wb(1'b1, ADR_ELEM_EN, 32'h1);
		passes(2);
		check("latch_clr", 32'h18, {27'h0, vout[8:4] & 5'h19});
		wb(1'b0, ADR_LATCH, 32'h0);
		check("latch_reg", 32'h0, rd);
	endtask

	task automatic t_timer;
		wb(1'b1, 12'h100, {16'h2, 16'h3});
		wb(1'b1, ADR_VIN, 32'h4);
		passes(2);
		check("tmr_early", 32'h0, {31'h0, vout[5]});
		passes(4);
		check("tmr_pick", 32'h1, {31'h0, vout[5]});
		wb(1'b1, ADR_VIN, 32'h0);
		passes(1);
		check("tmr_hold", 32'h1, {31'h0, vout[5]});
		passes(4);
		check("tmr_drop", 32'h0, {31'h0, vout[5]});
		wb(1'b1, ADR_TMR_UNIT, 32'h1);
		wb(1'b1, ADR_VIN, 32'h4);
		passes(6);
		check("tmr_sec", 32'h0, {31'h0, vout[5]});
	endtask

	task automatic t_cmp;
		logic [31:0] cc [11] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h203, 32'h803, 32'h801,
			32'h43, 32'h21, 32'h1003, 32'h2};
		int av [11] = '{2000, 990, 960, -2000, -2000, 500, 2000, 2000, -2000, 2000, 2000};
		logic [0:10] ce = 11'h664;
		logic        hit;
		atype <= 32'h21;
		wb(1'b1, 12'h204, 32'h3e8);
		wb(1'b1, 12'h208, 32'h1e);
		for (int i = 0; i < 11; i++) begin
			wb(1'b1, 12'h200, cc[i]);
			ain[31:0] <= 32'(av[i]);
			passes(2);
			wb(1'b0, 12'h218, 32'h0);
			check("cmp", {28'h0, {4{ce[i]}}}, {28'h0, opr[0], pkp[0], rd[1:0]});
		end
		wb(1'b1, 12'h210, 32'h3);
		wb(1'b1, 12'h200, 32'h3);
		passes(2);
		check("cmp_dly", 32'h1, {30'h0, opr[0], pkp[0]});
		passes(3);
		check("cmp_dly", 32'h3, {30'h0, opr[0], pkp[0]});
		wb(1'b1, 12'h200, 32'h403);
		ain[31:0] <= 32'h0;
		passes(21);
		ain[31:0] <= 32'h7d0;
		hit = 1'b0;
		repeat (21 * PC) begin
			@(posedge clk);
			hit = hit | (pkp[0] === 1'b1);
		end
		check("cmp_delta", 32'h1, {31'h0, hit});
		passes(21);
		check("cmp_delta", 32'h0, {31'h0, pkp[0]});
	endtask

	initial begin
		rst = 1'b1;
		{cyc, stb, we, adr, wdat, sel} = '0;
		contact = 32'h1;
		elem = 32'h1;
		ain = '0;
		atype = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_bus();
		t_program();
		t_status();
		t_latch();
		t_timer();
		t_cmp();
		test_done();
	end

	initial begin
		repeat (95000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule // test_lce_engine
`default_nettype wire
